// [design/aofc_pkg.sv]
// Constants and carrier types for the analog-output and FIFO control bank.
package aofc_pkg;

    // Clock rate of aclk.
    localparam int unsigned CLK_HZ = 25_000_000;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_IRQ_FIFO = 8'h08;
    localparam logic [7:0] IDX_AOUT = 8'h0a;
    localparam logic [7:0] IDX_CH0_CODE = 8'h0c;
    localparam logic [7:0] IDX_CH1_CODE = 8'h0e;
    localparam logic [7:0] IDX_STREAM = 8'h30;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h40;
    localparam logic [7:0] IDX_EVT_MASK = 8'h41;
    localparam logic [7:0] IDX_PACER_DIV = 8'h42;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;

    // Clear register bits.
    localparam int CLR_IN_FLUSH = 11;
    localparam int CLR_OUT_FLUSH = 15;

    // Interrupt and FIFO status bits.
    localparam int ST_INT = 0;
    localparam int ST_IN_EMPTY = 8;
    localparam int ST_IN_HALF = 9;
    localparam int ST_IN_FULL = 10;
    localparam int ST_OUT_EMPTY = 12;
    localparam int ST_OUT_HALF = 13;
    localparam int ST_OUT_FULL = 14;

    // Output control and status bits.
    localparam int CT_CH0_LEVEL = 0;
    localparam int CT_CH0_SRC = 1;
    localparam int CT_CH0_POL = 2;
    localparam int CT_CH1_LEVEL = 4;
    localparam int CT_CH1_SRC = 5;
    localparam int CT_CH1_POL = 6;
    localparam int CT_CH0_CONT = 8;
    localparam int CT_CH1_CONT = 9;
    localparam int CT_PACER_SRC = 11;
    localparam int CT_TRIG = 15;

    // Sample code width.
    localparam int CODE_W = 12;

    // Event bits of the interrupt status and mask registers.
    localparam int EVT_TRIG = 0;
    localparam int EVT_OUT_EMPTY = 1;
    localparam int EVT_OUT_LOW = 2;
    localparam int EVT_W = 3;

    // Values after reset.
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
    localparam logic [15:0] PACER_DIV_RESET = 16'h0018;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic polarity_sel;
        logic ref_source_sel;
        logic ref_level_sel;
    } aofc_chan_cfg_t;

    typedef struct packed {
        logic full;
        logic half;
        logic empty;
    } aofc_fifo_flags_t;

endpackage

// [design/aofc_regs.sv]
// Analog-output control bank with output FIFO, pacer and AXI4-Lite slave.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Any write touching the clear register low byte clears the pending interrupt.
// - Writing zero to clear bit 11 flushes the input FIFO.
// - Writing zero to clear bit 15 flushes the output FIFO.
// - Status bit 0 reads one while an uncleared interrupt is pending.
// - Status bits 8, 9, 10 show input FIFO empty, half-full, full.
// - Status bits 12, 13, 14 show output FIFO empty, half-full, full.
// - Control bit 0 picks channel 0 internal reference, low or high level.
// - Control bit 1 picks channel 0 reference, internal or external pin.
// - Control bit 2 picks channel 0 polarity, unipolar or bipolar.
// - Control bits 4, 5, 6 configure channel 1 likewise.
// - Bits 8 and 9 put channels 0 and 1 into continuous output.
// - Bit 11 picks internal or external pacer; external only when continuous.
// - Status bit 15 reads one once the external trigger has arrived.
// - Writing one to the trigger flag acts as a trigger, continuous only.
// - Sample words carry a 12-bit code in bits 11 down to 0.
// - Channel data registers update outputs only in single-value mode.
// - In continuous mode stream register writes are queued into the FIFO.
module aofc_regs
#(
    parameter int ADDR_W = 12,
    parameter int DEPTH = 32
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter settings and codes.
    output aofc_pkg::aofc_chan_cfg_t ch0_cfg,
    output aofc_pkg::aofc_chan_cfg_t ch1_cfg,
    output logic [aofc_pkg::CODE_W-1:0] ch0_code,
    output logic [aofc_pkg::CODE_W-1:0] ch1_code,
    output logic ch0_load,
    output logic ch1_load,
    // External pins.
    input wire logic out_ext_pacer_pin,
    input wire logic out_ext_trigger_pin,
    // Input-converter FIFO.
    input wire aofc_pkg::aofc_fifo_flags_t in_fifo_flags,
    output logic in_fifo_flush,
    // Interrupt.
    output logic irq
);
    import aofc_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(DEPTH / 2);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and block state.
    logic aw_held, w_held, wr_fire, wr_ok, rd_fire, rd_ok;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] wdata_q, rd_value;
    logic [3:0] wstrb_q;
    logic [IDX_W-1:0] wr_idx, rd_idx;
    logic [15:0] ctrl, pacer_div, pacer_cnt;
    logic trig_flag, trig_pin_q, pacer_pin_q, turn_ch1, cont_any, run, tick;
    logic push, pop, out_flush, pop_to_ch1, int_flag;
    logic trig_sw, trig_sw_clr, trig_rise;
    logic [EVT_W-1:0] evt_status, evt_mask, evt_set, evt_clr;
    logic [CODE_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr;
    logic [CNT_W-1:0] count;
    aofc_fifo_flags_t out_flags, out_flags_q;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, then answered.
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_idx = aw_addr_q[IDX_LSB +: IDX_W];
    assign wr_ok = (aw_addr_q >> (IDX_LSB + IDX_W)) == '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                wready <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok && (wr_idx inside {IDX_IRQ_FIFO, IDX_AOUT,
                    IDX_CH0_CODE, IDX_CH1_CODE, IDX_STREAM, IDX_EVT_STATUS,
                    IDX_EVT_MASK, IDX_PACER_DIV}) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data.
    assign rd_fire = arvalid && arready;
    assign rd_idx = araddr[IDX_LSB +: IDX_W];
    assign int_flag = |(evt_status & evt_mask);

    always_comb
    begin
        rd_value = 32'h0;
        rd_ok = (araddr >> (IDX_LSB + IDX_W)) == '0;
        unique case (rd_idx)
            IDX_IRQ_FIFO:
            begin
                rd_value[ST_INT] = int_flag;
                rd_value[ST_IN_FULL:ST_IN_EMPTY] = in_fifo_flags;
                rd_value[ST_OUT_FULL:ST_OUT_EMPTY] = out_flags;
            end
            IDX_AOUT:
            begin
                rd_value[15:0] = ctrl;
                rd_value[CT_CH0_SRC] = 1'b0;
                rd_value[CT_CH1_SRC] = 1'b0;
                rd_value[CT_TRIG] = trig_flag;
            end
            IDX_EVT_STATUS: rd_value[EVT_W-1:0] = evt_status;
            IDX_EVT_MASK: rd_value[EVT_W-1:0] = evt_mask;
            IDX_PACER_DIV: rd_value[15:0] = pacer_div;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_value : 32'h0;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and settings driven to the converters.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= CTRL_RESET;
            pacer_div <= PACER_DIV_RESET;
            evt_mask <= MASK_RESET;
        end
        else if (wr_fire && wr_ok)
        begin
            if (wr_idx == IDX_AOUT && wstrb_q[0])
                ctrl[7:0] <= wdata_q[7:0];
            if (wr_idx == IDX_AOUT && wstrb_q[1])
                ctrl[14:8] <= wdata_q[14:8];
            if (wr_idx == IDX_PACER_DIV && wstrb_q[0])
                pacer_div[7:0] <= wdata_q[7:0];
            if (wr_idx == IDX_PACER_DIV && wstrb_q[1])
                pacer_div[15:8] <= wdata_q[15:8];
            if (wr_idx == IDX_EVT_MASK && wstrb_q[0])
                evt_mask <= wdata_q[EVT_W-1:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_cfg <= '0;
            ch1_cfg <= '0;
        end
        else
        begin
            ch0_cfg <= {ctrl[CT_CH0_POL], ctrl[CT_CH0_SRC],
                ctrl[CT_CH0_LEVEL]};
            ch1_cfg <= {ctrl[CT_CH1_POL], ctrl[CT_CH1_SRC],
                ctrl[CT_CH1_LEVEL]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger flag: external edge or software write, set over clear.
    assign cont_any = ctrl[CT_CH0_CONT] || ctrl[CT_CH1_CONT];
    assign trig_rise = out_ext_trigger_pin && !trig_pin_q;
    assign trig_sw = wr_fire && wr_ok && wr_idx == IDX_AOUT && wstrb_q[1]
        && wdata_q[CT_TRIG] && (wdata_q[CT_CH0_CONT] || wdata_q[CT_CH1_CONT]);
    assign trig_sw_clr = wr_fire && wr_ok && wr_idx == IDX_AOUT
        && wstrb_q[1] && !wdata_q[CT_TRIG];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_flag <= 1'b0;
            trig_pin_q <= 1'b0;
        end
        else
        begin
            trig_pin_q <= out_ext_trigger_pin;
            if (trig_rise || trig_sw)
                trig_flag <= 1'b1;
            else if (trig_sw_clr)
                trig_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pacer: internal divider or external pin edge.
    assign run = cont_any && trig_flag;
    assign tick = run && (ctrl[CT_PACER_SRC]
        ? (out_ext_pacer_pin && !pacer_pin_q)
        : (pacer_cnt == 16'h0));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pacer_cnt <= PACER_DIV_RESET;
            pacer_pin_q <= 1'b0;
        end
        else
        begin
            pacer_pin_q <= out_ext_pacer_pin;
            if (!run || pacer_cnt == 16'h0)
                pacer_cnt <= pacer_div;
            else
                pacer_cnt <= pacer_cnt - 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output FIFO.
    assign out_flush = wr_fire && wr_ok && wr_idx == IDX_IRQ_FIFO
        && wstrb_q[1] && !wdata_q[CLR_OUT_FLUSH];
    assign push = wr_fire && wr_ok && wr_idx == IDX_STREAM && wstrb_q[0]
        && count != CNT_FULL;
    assign pop = tick && count != '0;
    assign out_flags.empty = count == '0;
    assign out_flags.half = count >= CNT_HALF;
    assign out_flags.full = count == CNT_FULL;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || out_flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= wdata_q[CODE_W-1:0];
                wr_ptr <= PTR_W'(wr_ptr + 1'b1);
            end
            if (pop)
                rd_ptr <= PTR_W'(rd_ptr + 1'b1);
            count <= CNT_W'(count + CNT_W'(push) - CNT_W'(pop));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter codes: direct writes in single mode, FIFO pops otherwise.
    assign pop_to_ch1 = ctrl[CT_CH1_CONT]
        && (!ctrl[CT_CH0_CONT] || turn_ch1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_code <= '0;
            ch1_code <= '0;
            ch0_load <= 1'b0;
            ch1_load <= 1'b0;
            turn_ch1 <= 1'b0;
        end
        else
        begin
            ch0_load <= 1'b0;
            ch1_load <= 1'b0;
            if (!cont_any)
                turn_ch1 <= 1'b0;
            if (pop)
            begin
                turn_ch1 <= !pop_to_ch1;
                if (pop_to_ch1)
                begin
                    ch1_code <= mem[rd_ptr];
                    ch1_load <= 1'b1;
                end
                else
                begin
                    ch0_code <= mem[rd_ptr];
                    ch0_load <= 1'b1;
                end
            end
            if (wr_fire && wr_ok && wstrb_q[0])
            begin
                if (wr_idx == IDX_CH0_CODE && !ctrl[CT_CH0_CONT])
                begin
                    ch0_code <= wdata_q[CODE_W-1:0];
                    ch0_load <= 1'b1;
                end
                if (wr_idx == IDX_CH1_CODE && !ctrl[CT_CH1_CONT])
                begin
                    ch1_code <= wdata_q[CODE_W-1:0];
                    ch1_load <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, interrupt and input FIFO flush.
    assign evt_set[EVT_TRIG] = (trig_rise || trig_sw) && !trig_flag;
    assign evt_set[EVT_OUT_EMPTY] = out_flags.empty && !out_flags_q.empty;
    assign evt_set[EVT_OUT_LOW] = !out_flags.half && out_flags_q.half;
    assign evt_clr = {EVT_W{(rd_fire && rd_ok && rd_idx == IDX_EVT_STATUS)
        || (wr_fire && wr_ok && wr_idx == IDX_IRQ_FIFO && wstrb_q[0])}};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_status <= '0;
            out_flags_q <= 3'h1;
            irq <= 1'b0;
            in_fifo_flush <= 1'b0;
        end
        else
        begin
            out_flags_q <= out_flags;
            evt_status <= (evt_status & ~evt_clr) | evt_set;
            irq <= |(((evt_status & ~evt_clr) | evt_set) & evt_mask);
            in_fifo_flush <= wr_fire && wr_ok && wr_idx == IDX_IRQ_FIFO
                && wstrb_q[1] && !wdata_q[CLR_IN_FLUSH];
        end
    end

endmodule
`default_nettype wire

// [verif/aofc_regs_assertions.sv]
// Port-level checks for the output control bank.
`timescale 1ns/10ps
`default_nettype none
module aofc_regs_assertions
#(
    parameter int ADDR_W = 12,
    parameter int DEPTH = 32
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write bus.
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // Read bus.
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // Converter side, pins and interrupt.
    input wire aofc_pkg::aofc_chan_cfg_t ch0_cfg,
    input wire aofc_pkg::aofc_chan_cfg_t ch1_cfg,
    input wire logic [aofc_pkg::CODE_W-1:0] ch0_code,
    input wire logic [aofc_pkg::CODE_W-1:0] ch1_code,
    input wire logic ch0_load,
    input wire logic ch1_load,
    input wire logic out_ext_pacer_pin,
    input wire logic out_ext_trigger_pin,
    input wire aofc_pkg::aofc_fifo_flags_t in_fifo_flags,
    input wire logic in_fifo_flush,
    input wire logic irq
);
    import aofc_pkg::*;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response withdrawn early");
    chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data withdrawn early");
    chk_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_read_busy: assert property (rvalid |-> !arready)
        else $error("read address accepted while busy");
    chk_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while busy");
    chk_b_release: assert property (bvalid && bready |=> !bvalid && awready)
        else $error("write response not released");
    chk_r_release: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read response not released");
    chk_err_zero:
        assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
        else $error("error read carries data");
    chk_flush_pulse:
        assert property (in_fifo_flush |=> !in_fifo_flush)
        else $error("flush pulse too long");
    chk_flush_cause:
        assert property (in_fifo_flush |-> bvalid || $past(bvalid))
        else $error("flush without a write");
    chk_code0_load:
        assert property ($changed(ch0_code) |-> ch0_load)
        else $error("channel 0 code moved without load");
    chk_code1_load:
        assert property ($changed(ch1_code) |-> ch1_load)
        else $error("channel 1 code moved without load");
endmodule
bind aofc_regs aofc_regs_assertions #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ch0_cfg(ch0_cfg),
    .ch1_cfg(ch1_cfg), .ch0_code(ch0_code), .ch1_code(ch1_code),
    .ch0_load(ch0_load), .ch1_load(ch1_load),
    .out_ext_pacer_pin(out_ext_pacer_pin),
    .out_ext_trigger_pin(out_ext_trigger_pin),
    .in_fifo_flags(in_fifo_flags), .in_fifo_flush(in_fifo_flush), .irq(irq)
);
`default_nettype wire

// [verif/aofc_regs_bench.sv]
// Self-checking bench for the output control bank.
`timescale 1ns/10ps
`default_nettype none
module aofc_regs_bench;
    import aofc_pkg::*;
    localparam int DEPTH = 32;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ch0_load, ch1_load;
    logic out_ext_pacer_pin, out_ext_trigger_pin, in_fifo_flush, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [CODE_W-1:0] ch0_code, ch1_code;
    aofc_chan_cfg_t ch0_cfg, ch1_cfg;
    aofc_fifo_flags_t in_fifo_flags;
    logic [33:0] rq[$];
    logic [31:0] rm[$];
    logic [1:0] bq[$];
    logic [12:0] lq[$];
    int bad_count, compares, flushes, i, c;
    logic [15:0] d;
    logic [31:0] m;

    aofc_regs #(.ADDR_W(12), .DEPTH(DEPTH)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .ch0_cfg(ch0_cfg),
        .ch1_cfg(ch1_cfg), .ch0_code(ch0_code), .ch1_code(ch1_code),
        .ch0_load(ch0_load), .ch1_load(ch1_load),
        .out_ext_pacer_pin(out_ext_pacer_pin),
        .out_ext_trigger_pin(out_ext_trigger_pin),
        .in_fifo_flags(in_fifo_flags), .in_fifo_flush(in_fifo_flush),
        .irq(irq)
    );

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask

    task automatic finish_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] dat,
        input logic [3:0] st = 4'h3, input logic [1:0] er = RESP_OKAY);
        logic a;
        logic w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        bq.push_back(er);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {16'($urandom()), dat};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w))
        begin
            @(posedge aclk);
            a = a | awready;
            w = w | wready;
            awvalid <= !a;
            wvalid <= !w;
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] dat,
        input logic [31:0] msk = 32'hffffffff, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        rq.push_back({er, dat});
        rm.push_back(msk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask

    // Streams n random samples and notes where each should come out.
    task automatic push_n(input int n, input logic ch);
        logic [15:0] s;
        repeat (n)
        begin
            s = 16'($urandom());
            lq.push_back({ch, s[11:0]});
            wr(IDX_STREAM, s);
        end
    endtask

    task automatic pulse(input logic trig);
        @(posedge aclk);
        if (trig)
            out_ext_trigger_pin <= 1'b1;
        else
            out_ext_pacer_pin <= 1'b1;
        repeat (3) @(posedge aclk);
        out_ext_trigger_pin <= 1'b0;
        out_ext_pacer_pin <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        if (aresetn && bvalid && bready)
            check(bresp, bq.size() ? bq.pop_front() : 2'h3);
        if (aresetn && rvalid && rready)
        begin
            m = rm.size() ? rm.pop_front() : 32'h0;
            check({rresp, rdata & m},
                rq.size() ? rq.pop_front() & {2'h3, m} : '1);
        end
        if (aresetn && ch0_load)
            check({1'b0, ch0_code}, lq.size() ? lq.pop_front() : '1);
        if (aresetn && ch1_load)
            check({1'b1, ch1_code}, lq.size() ? lq.pop_front() : '1);
        if (aresetn && in_fifo_flush)
            flushes++;
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {out_ext_pacer_pin, out_ext_trigger_pin} = 2'h0;
        {awaddr, araddr, wdata, wstrb} = 60'h0;
        in_fifo_flags = 3'h1;
        c = $urandom(58800);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_AOUT, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            in_fifo_flags <= aofc_fifo_flags_t'(i[2:0]);
            rd(IDX_IRQ_FIFO, {16'h0, 4'h1, 1'b0, i[2:0], 8'h0}, 32'h7700);
        end
        for (i = 0; i < 4; i++)
        begin
            d = 16'($urandom()) & 16'h0877;
            wr(IDX_AOUT, d);
            rd(IDX_AOUT, {16'h0, d & 16'hffdd});
            check({ch1_cfg, ch0_cfg}, {d[6:4], d[2:0]});
        end
        wr(IDX_AOUT, 16'h0000);
        for (i = 0; i < 4; i++)
        begin
            d = 16'($urandom());
            lq.push_back({i[0], d[11:0]});
            wr(i[0] ? IDX_CH1_CODE : IDX_CH0_CODE, d);
        end
        wr(IDX_AOUT, 16'h0100);
        wr(IDX_CH0_CODE, 16'h0abc);
        wr(8'h20, 16'h1234, 4'h3, RESP_SLVERR);
        rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
        for (i = 0; i < DEPTH + 1; i++)
        begin
            wr(IDX_STREAM, 16'($urandom()));
            if (i == DEPTH / 2 - 1)
                rd(IDX_IRQ_FIFO, 32'h2000, 32'h7000);
        end
        rd(IDX_IRQ_FIFO, 32'h6000, 32'h7000);
        c = flushes;
        wr(IDX_IRQ_FIFO, 16'h8800);
        rd(IDX_IRQ_FIFO, 32'h6000, 32'h7000);
        wr(IDX_IRQ_FIFO, 16'h0000);
        rd(IDX_IRQ_FIFO, 32'h1000, 32'h7000);
        check(flushes, c + 1);
        wr(IDX_PACER_DIV, 16'h0003);
        push_n(3, 1'b0);
        wr(IDX_AOUT, 16'h8100);
        rd(IDX_AOUT, 32'h8100);
        repeat (12) @(posedge aclk);
        check(lq.size(), 0);
        wr(IDX_AOUT, 16'h0a00);
        push_n(3, 1'b1);
        wr(IDX_AOUT, 16'h8a00);
        pulse(1'b0);
        pulse(1'b0);
        check(lq.size(), 1);
        pulse(1'b0);
        check(lq.size(), 0);
        push_n(1, 1'b0);
        push_n(1, 1'b1);
        wr(IDX_AOUT, 16'h8300);
        repeat (12) @(posedge aclk);
        check(lq.size(), 0);
        wr(IDX_AOUT, 16'h0000);
        rd(IDX_EVT_STATUS, 32'h0, 32'h0);
        wr(IDX_EVT_MASK, 16'h0001);
        pulse(1'b1);
        rd(IDX_AOUT, 32'h8000);
        check(irq, 1'b1);
        rd(IDX_IRQ_FIFO, 32'h1, 32'h1);
        wr(IDX_IRQ_FIFO, 16'($urandom()), 4'h1);
        rd(IDX_IRQ_FIFO, 32'h0, 32'h1);
        check(irq, 1'b0);
        wr(IDX_AOUT, 16'h0000);
        wr(IDX_AOUT, 16'h8000);
        rd(IDX_AOUT, 32'h0);
        wr(IDX_EVT_MASK, 16'h0000);
        pulse(1'b1);
        check(irq, 1'b0);
        rd(IDX_EVT_STATUS, 32'h1, 32'h1);
        rd(IDX_EVT_STATUS, 32'h0, 32'h1);
        repeat (4) @(posedge aclk);
        check(lq.size() + rq.size() + bq.size(), 0);
        finish_test();
    end
endmodule
`default_nettype wire
